// [cis_chk.sv]
// Checker: port-level assertions for the charger input supervisor
`timescale 1ns/1ps
module cis_chk
    import cis_pkg::*;
(
    input wire logic                 clock,
    input wire logic                 rst_b,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic [31:0]          s_axi_rdata,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready,
    input wire logic [CIS_MV_W-1:0]  supplyMv,
    input wire logic                 ac_mode_input,
    input wire logic                 charge_level_input,
    input wire logic                 batteryPresent,
    input wire logic [11:0]          fastChargeMa,
    input wire logic                 chargeEnable,
    input wire logic                 chargeSuspend,
    input wire logic [11:0]          inputLimitMa,
    input wire logic [11:0]          chargeCurrentMa,
    input wire cis_src_e             system_rail_source,
    input wire logic                 irq_out_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////////////////////
    // Pins pass two sync flops and one register, so four held samples settle an output
    sequence overV;  (supplyMv > OVP_MV_3) [*4]; endsequence
    sequence underV; (supplyMv < UVLO_MV) [*4]; endsequence
    sequence usbLo;  (!ac_mode_input && !charge_level_input) [*4]; endsequence
    sequence usbHi;  (!ac_mode_input && charge_level_input) [*4]; endsequence
    sequence acHi;   (ac_mode_input && charge_level_input) [*4]; endsequence
    ////////////////////////////////////////////////////////////////////////////////////////////
    rst_idle_a: assert property (disable iff (1'b0) !rst_b |=> irq_out_n && !chargeEnable && !s_axi_rvalid && !s_axi_bvalid)
        else $error("outputs not idle after reset");
    read_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    susp_compl_a: assert property (chargeSuspend != chargeEnable)
        else $error("suspend and enable disagree");
    ovp_inhib_a: assert property (overV |-> !chargeEnable)
        else $error("charging above over-voltage limit");
    uv_off_a: assert property (underV |-> !chargeEnable && system_rail_source == CIS_SRC_BATTERY)
        else $error("charging or input source under voltage");
    usb_lo_a: assert property (usbLo |-> inputLimitMa == ILIM_USB_LO_MA)
        else $error("usb low limit wrong");
    usb_hi_a: assert property (usbHi |-> inputLimitMa == ILIM_USB_HI_MA)
        else $error("usb high limit wrong");
    ac_cur_a: assert property (acHi |-> inputLimitMa == ILIM_AC_MA && chargeCurrentMa == fastChargeMa)
        else $error("ac mode current wrong");
    no_batt_a: assert property ((!batteryPresent) [*5] |-> chargeSuspend)
        else $error("no suspend without battery");
endmodule

bind cis_top cis_chk chk (.*);

// [cis_host.sv]
// Host model: AXI4-Lite master standing in for the system processor
`timescale 1ns/1ps
module cis_host (
    input  wire logic        clock,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    ////////////////////////////////////////////////////////////////////////////////////////////
    // Each address and data channel is released only at the edge where its own ready was seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // The status word carries clear-on-read, valid and AC-level together
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

// [cis_pkg.sv]
// Package: register map, field positions, reset values and codes for the charger input supervisor
package cis_pkg;

    // Register byte addresses
    localparam logic [7:0] CIS_ADDR_CTRL    = 8'h00;
    localparam logic [7:0] CIS_ADDR_STATUS  = 8'h04;
    localparam logic [7:0] CIS_ADDR_IRQSTAT = 8'h08;
    localparam logic [7:0] CIS_ADDR_IRQCLR  = 8'h0C;
    localparam logic [7:0] CIS_ADDR_IRQEN   = 8'h10;

    // CTRL fields
    localparam int CTRL_OVP_LSB   = 0;
    localparam int CTRL_INPUT_IRQ_STATUS_EN = 2;
    localparam int CTRL_CON_EN    = 3;
    localparam int CTRL_DIS_EN    = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // STATUS fields
    localparam int ST_INPUT_IRQ_STATUS   = 0;
    localparam int ST_VALID    = 1;
    localparam int ST_ACLEVEL  = 2;
    localparam int ST_UVLO     = 3;
    localparam int ST_OVLATCH  = 4;
    localparam int ST_SUSPEND  = 5;

    // Event bits of IRQSTAT / IRQCLR / IRQEN
    localparam int EV_CONNECT    = 0;
    localparam int EV_DISCONNECT = 1;
    localparam int EV_OVP        = 2;
    localparam int EV_UVLO       = 3;
    localparam int EV_NUM        = 4;
    localparam logic [3:0] IRQEN_RESET = 4'h0;

    // Supply thresholds in millivolts, compared against a 14-bit sample
    localparam int CIS_MV_W = 14;
    localparam logic [13:0] OVP_MV_0    = 14'd6600;
    localparam logic [13:0] OVP_MV_1    = 14'd7000;
    localparam logic [13:0] OVP_MV_2    = 14'd7500;
    localparam logic [13:0] OVP_MV_3    = 14'd8000;
    localparam logic [13:0] OV_RESUME_MV = 14'd6000;
    localparam logic [13:0] UVLO_MV      = 14'd3500;
    localparam logic [13:0] UVLO_HYST_MV = 14'd500;

    // Current limits
    localparam logic [11:0] ILIM_USB_LO_MA = 12'd100;
    localparam logic [11:0] ILIM_USB_HI_MA = 12'd450;
    localparam logic [11:0] ILIM_AC_MA     = 12'd2000;
    localparam int          AC_LOW_DIVISOR = 5;

    // AXI responses
    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    // Power-path source
    typedef enum logic [1:0] {
        CIS_SRC_BATTERY = 2'b00,
        CIS_SRC_INPUT   = 2'b01,
        CIS_SRC_BOTH    = 2'b10
    } cis_src_e;

endpackage

// [cis_threshold.sv]
// Supply qualification: over-voltage latch with resume ceiling and under-voltage hysteresis
`timescale 1ns/1ps
module cis_threshold (
    input  wire logic                          clock,
    input  wire logic                          rst_b,
    input  wire logic [cis_pkg::CIS_MV_W-1:0]  supplyMv,
    input  wire logic [1:0]                    ovpSelect,
    output logic                               ovLatched,
    output logic                               uvLocked,
    output logic                               inputValid
);
    import cis_pkg::*;

    typedef struct packed {
        logic ov;
        logic uv;
    } cis_thr_s;

    cis_thr_s st;
    cis_thr_s next_st;
    logic [CIS_MV_W-1:0] ovpLimit;
    logic [CIS_MV_W-1:0] uvRelease;

    always_comb begin
        case (ovpSelect)
            2'b00:   ovpLimit = OVP_MV_0;
            2'b01:   ovpLimit = OVP_MV_1;
            2'b10:   ovpLimit = OVP_MV_2;
            default: ovpLimit = OVP_MV_3;
        endcase
        uvRelease = UVLO_MV + UVLO_HYST_MV;
        next_st = st;
        if (supplyMv > ovpLimit) begin
            next_st.ov = 1'b1;
        end else if (supplyMv < OV_RESUME_MV) begin
            next_st.ov = 1'b0;
        end
        if (supplyMv < UVLO_MV) begin
            next_st.uv = 1'b1;
        end else if (supplyMv >= uvRelease) begin
            next_st.uv = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st <= '{ov: 1'b0, uv: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign ovLatched  = st.ov;
    assign uvLocked   = st.uv;
    assign inputValid = !st.ov && !st.uv;
endmodule

// [cis_top.sv]
// Charger input supervisor: AXI4-Lite registers, input qualification, current limits, interrupts
`timescale 1ns/1ps
module cis_top (
    input  wire logic                          clock,
    input  wire logic                          rst_b,
    // AXI4-Lite slave
    input  wire logic [7:0]                    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [7:0]                    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // Analog front end and pins
    input  wire logic [cis_pkg::CIS_MV_W-1:0]  supplyMv,
    input  wire logic                          ac_mode_input,
    input  wire logic                          charge_level_input,
    input  wire logic                          batteryPresent,
    input  wire logic                          systemOverload,
    input  wire logic [11:0]                   fastChargeMa,
    output logic                               chargeEnable,
    output logic                               chargeSuspend,
    output logic [11:0]                        inputLimitMa,
    output logic [11:0]                        chargeCurrentMa,
    output cis_pkg::cis_src_e                  system_rail_source,
    output logic                               irq_out_n
);
    import cis_pkg::*;

    typedef struct packed {
        logic [1:0]  acSync;
        logic [1:0]  lvlSync;
        logic [1:0]  batSync;
        logic [1:0]  ovlSync;
        logic        validPrev;
        logic        validPrevOk;
        logic [1:0]  ovpSel;
        logic        instatEn;
        logic        conEn;
        logic        disEn;
        logic        input_irq_status;
        logic [3:0]  irqStat;
        logic [3:0]  irqEn;
        logic        ovPrev;
        logic        uvPrev;
        logic        awHeld;
        logic [7:0]  awAddr;
        logic        wHeld;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
        logic        enable;
        logic        suspend;
        logic [11:0] iLimit;
        logic [11:0] iChg;
        logic [1:0]  src;
    } cis_state_s;

    cis_state_s st;
    cis_state_s next_st;

    // Power-on state: registers at their reset values, limits lowest, charger suspended
    localparam cis_state_s ST_RESET = '{
        acSync:      2'h0,
        lvlSync:     2'h0,
        batSync:     2'h0,
        ovlSync:     2'h0,
        validPrev:   1'b0,
        validPrevOk: 1'b0,
        ovpSel:      CTRL_RESET[CTRL_OVP_LSB +: 2],
        instatEn:    CTRL_RESET[CTRL_INPUT_IRQ_STATUS_EN],
        conEn:       CTRL_RESET[CTRL_CON_EN],
        disEn:       CTRL_RESET[CTRL_DIS_EN],
        input_irq_status:      1'b0,
        irqStat:     4'h0,
        irqEn:       IRQEN_RESET,
        ovPrev:      1'b0,
        uvPrev:      1'b0,
        awHeld:      1'b0,
        awAddr:      8'h00,
        wHeld:       1'b0,
        wData:       32'h00000000,
        wStrb:       4'h0,
        bValid:      1'b0,
        bResp:       AXI_OKAY,
        rValid:      1'b0,
        rData:       32'h00000000,
        rResp:       AXI_OKAY,
        enable:      1'b0,
        suspend:     1'b1,
        iLimit:      ILIM_USB_LO_MA,
        iChg:        ILIM_USB_LO_MA,
        src:         CIS_SRC_BATTERY
    };

    logic ovLatched;
    logic uvLocked;
    logic inputValid;

    cis_threshold u_thr (
        .clock      (clock),
        .rst_b      (rst_b),
        .supplyMv   (supplyMv),
        .ovpSelect  (st.ovpSel),
        .ovLatched  (ovLatched),
        .uvLocked   (uvLocked),
        .inputValid (inputValid)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////

    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == CIS_ADDR_CTRL) || (a == CIS_ADDR_STATUS) || (a == CIS_ADDR_IRQSTAT)
                || (a == CIS_ADDR_IRQCLR) || (a == CIS_ADDR_IRQEN);
    endfunction

    logic        acLevel;
    logic        chgLevel;
    logic        batOk;
    logic        doWrite;
    logic        doRead;
    logic [3:0]  events;
    logic        connectEv;
    logic        disconnectEv;
    logic [31:0] ctrlWord;
    logic [31:0] statusWord;
    logic [31:0] wMasked;

    always_comb begin
        next_st = st;
        // Only the second flop of each chain feeds logic
        acLevel  = st.acSync[1];
        chgLevel = st.lvlSync[1];
        batOk    = st.batSync[1];

        // Pins cross into the clock domain through two flops
        next_st.acSync  = {st.acSync[0], ac_mode_input};
        next_st.lvlSync = {st.lvlSync[0], charge_level_input};
        next_st.batSync = {st.batSync[0], batteryPresent};
        next_st.ovlSync = {st.ovlSync[0], systemOverload};

        // Edges of the qualified input; first sample after reset only primes the history
        next_st.validPrev   = inputValid;
        next_st.validPrevOk = 1'b1;
        connectEv    = st.validPrevOk && inputValid && !st.validPrev;
        disconnectEv = st.validPrevOk && !inputValid && st.validPrev;
        next_st.ovPrev = ovLatched;
        next_st.uvPrev = uvLocked;
        events = '0;
        events[EV_CONNECT]    = connectEv;
        events[EV_DISCONNECT] = disconnectEv;
        events[EV_OVP]        = ovLatched && !st.ovPrev;
        // Reset starts UV-locked, so the lock seen right after reset is no event
        events[EV_UVLO]       = uvLocked && !st.uvPrev && st.validPrevOk;

        ctrlWord = '0;
        ctrlWord[CTRL_OVP_LSB +: 2] = st.ovpSel;
        ctrlWord[CTRL_INPUT_IRQ_STATUS_EN]    = st.instatEn;
        ctrlWord[CTRL_CON_EN]       = st.conEn;
        ctrlWord[CTRL_DIS_EN]       = st.disEn;
        statusWord = '0;
        statusWord[ST_INPUT_IRQ_STATUS]  = st.input_irq_status;
        statusWord[ST_VALID]   = inputValid;
        statusWord[ST_ACLEVEL] = acLevel;
        statusWord[ST_UVLO]    = uvLocked;
        statusWord[ST_OVLATCH] = ovLatched;
        statusWord[ST_SUSPEND] = st.suspend;

        // Write channel: address and data may arrive in either order
        if (s_axi_awvalid && !st.awHeld && !st.bValid) begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.wHeld && !st.bValid) begin
            next_st.wHeld = 1'b1;
            next_st.wData = s_axi_wdata;
            next_st.wStrb = s_axi_wstrb;
        end
        doWrite = st.awHeld && st.wHeld && !st.bValid;
        // Only byte lane 0 carries register bits; a write without it changes nothing
        wMasked = st.wStrb[0] ? st.wData : 32'h00000000;
        if (doWrite) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld  = 1'b0;
            next_st.bValid = 1'b1;
            next_st.bResp  = isMapped(st.awAddr) ? AXI_OKAY : AXI_SLVERR;
            if (st.wStrb[0]) begin
                case (st.awAddr)
                    CIS_ADDR_CTRL: begin
                        next_st.ovpSel   = wMasked[CTRL_OVP_LSB +: 2];
                        next_st.instatEn = wMasked[CTRL_INPUT_IRQ_STATUS_EN];
                        next_st.conEn    = wMasked[CTRL_CON_EN];
                        next_st.disEn    = wMasked[CTRL_DIS_EN];
                    end
                    CIS_ADDR_IRQEN: begin
                        next_st.irqEn = wMasked[EV_NUM-1:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (st.bValid && s_axi_bready) begin
            next_st.bValid = 1'b0;
        end

        // Read channel: one read under way at a time
        // STATUS is captured as it stands at the taking edge, before its flag clears
        doRead = s_axi_arvalid && !st.rValid;
        if (doRead) begin
            next_st.rValid = 1'b1;
            next_st.rResp  = isMapped(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
            case (s_axi_araddr)
                CIS_ADDR_CTRL:    next_st.rData = ctrlWord;
                CIS_ADDR_STATUS:  next_st.rData = statusWord;
                CIS_ADDR_IRQSTAT: next_st.rData = {28'h0000000, st.irqStat};
                CIS_ADDR_IRQEN:   next_st.rData = {28'h0000000, st.irqEn};
                default:          next_st.rData = 32'h00000000;
            endcase
        end
        if (st.rValid && s_axi_rready) begin
            next_st.rValid = 1'b0;
        end

        // Reading STATUS clears the input flag, but a new event in that cycle wins
        if (doRead && s_axi_araddr == CIS_ADDR_STATUS) begin
            next_st.input_irq_status = 1'b0;
        end
        if (st.instatEn && ((connectEv && st.conEn) || (disconnectEv && st.disEn))) begin
            next_st.input_irq_status = 1'b1;
        end

        // Sticky event bits: write-one-to-clear, set wins
        if (doWrite && st.awAddr == CIS_ADDR_IRQCLR) begin
            next_st.irqStat = st.irqStat & ~wMasked[EV_NUM-1:0];
        end

        // A fault bit survives its clear while the fault stands, so the line stays low if that event is enabled in IRQEN
        if (ovLatched && st.irqStat[EV_OVP]) begin
            next_st.irqStat[EV_OVP] = 1'b1;
        end
        if (uvLocked && st.irqStat[EV_UVLO]) begin
            next_st.irqStat[EV_UVLO] = 1'b1;
        end
        next_st.irqStat = next_st.irqStat | events;

        // Charge control and current programming
        next_st.suspend = ovLatched || uvLocked || !batOk;
        next_st.enable  = !ovLatched && !uvLocked && batOk;
        if (acLevel) begin
            next_st.iLimit = ILIM_AC_MA;
            next_st.iChg   = chgLevel ? fastChargeMa
                           : 12'(fastChargeMa / AC_LOW_DIVISOR);
        end else begin
            next_st.iLimit = chgLevel ? ILIM_USB_HI_MA : ILIM_USB_LO_MA;
            next_st.iChg   = next_st.iLimit;
        end

        // Power path: input feeds system and battery; battery alone or both as needed
        if (!inputValid) begin
            next_st.src = CIS_SRC_BATTERY;
        end else if (st.ovlSync[1]) begin
            next_st.src = CIS_SRC_BOTH;
        end else begin
            next_st.src = CIS_SRC_INPUT;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////

    assign s_axi_awready = !st.awHeld && !st.bValid;
    assign s_axi_wready  = !st.wHeld && !st.bValid;
    assign s_axi_bvalid  = st.bValid;
    assign s_axi_bresp   = st.bResp;
    assign s_axi_arready = !st.rValid;
    assign s_axi_rvalid  = st.rValid;
    assign s_axi_rdata   = st.rData;
    assign s_axi_rresp   = st.rResp;

    assign chargeEnable       = st.enable;
    assign chargeSuspend      = st.suspend;
    assign inputLimitMa       = st.iLimit;
    assign chargeCurrentMa    = st.iChg;
    assign system_rail_source = cis_src_e'(st.src);
    // Held low while the input flag is pending or any enabled sticky event is set
    assign irq_out_n = !(st.input_irq_status || |(st.irqStat & st.irqEn));
endmodule

// [tb_charger_input_supervisor.sv]
// Testbench: register, interrupt and pin scenarios for the charger input supervisor
`timescale 1ns/1ps
module tb_charger_input_supervisor;
    import cis_pkg::*;
    logic              clock = 1'b0;
    logic              rst_b = 1'b0;
    logic [7:0]        s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata, d;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp, r;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [13:0]       supplyMv = 14'd0;
    logic              ac_mode_input = 1'b0, charge_level_input = 1'b0;
    logic              batteryPresent = 1'b1, systemOverload = 1'b0;
    logic [11:0]       fastChargeMa = 12'd1000, inputLimitMa, chargeCurrentMa;
    logic              chargeEnable, chargeSuspend, irq_out_n;
    cis_src_e          system_rail_source;
    logic [13:0]       ovp [4] = '{OVP_MV_0, OVP_MV_1, OVP_MV_2, OVP_MV_3};
    logic [11:0]       lim [4] = '{ILIM_USB_LO_MA, ILIM_USB_HI_MA, ILIM_AC_MA, ILIM_AC_MA};
    logic [11:0]       cur [4] = '{ILIM_USB_LO_MA, ILIM_USB_HI_MA, 12'd200, 12'd1000};
    int                failures = 0;
    int                compares = 0;

    always #25 clock = ~clock;
    cis_top  dut (.*);
    cis_host host (.*);
    ////////////////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e);
        host.rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, AXI_OKAY});
    endtask
    task wrc(input logic [7:0] a, input logic [31:0] v);
        host.wr(a, v, r);
        chk({30'h0, r}, {30'h0, AXI_OKAY});
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Events need two edges and pins three; six leaves margin for the irq register
    task sup(input logic [13:0] v);
        @(posedge clock);
        supplyMv <= v;
        cyc(6);
    endtask
    task conclude();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        conclude();
    end

    initial begin
        cyc(6);
        rst_b <= 1'b1;
        rdc(CIS_ADDR_CTRL, 32'h0);
        rdc(CIS_ADDR_IRQEN, 32'h0);
        rdc(CIS_ADDR_STATUS, 32'h28);
        chk(irq_out_n, 1'b1);
        wrc(CIS_ADDR_CTRL, 32'h1C);
        sup(14'd5000);
        chk(irq_out_n, 1'b0);
        rdc(CIS_ADDR_STATUS, 32'h03);
        rdc(CIS_ADDR_STATUS, 32'h02);
        cyc(2);
        chk(irq_out_n, 1'b1);
        sup(14'd3000);
        chk(irq_out_n, 1'b0);
        rdc(CIS_ADDR_STATUS, 32'h29);
        sup(14'd3900);
        rdc(CIS_ADDR_STATUS, 32'h28);
        sup(14'd4000);
        rdc(CIS_ADDR_STATUS, 32'h03);
        wrc(CIS_ADDR_CTRL, 32'h14);
        sup(14'd3000);
        rdc(CIS_ADDR_STATUS, 32'h29);
        sup(14'd5000);
        chk(irq_out_n, 1'b1);
        rdc(CIS_ADDR_STATUS, 32'h02);
        wrc(CIS_ADDR_IRQCLR, 32'hF);
        rdc(CIS_ADDR_IRQSTAT, 32'h0);
        for (int s = 0; s < 4; s++) begin
            wrc(CIS_ADDR_CTRL, s);
            sup(ovp[s]);
            rdc(CIS_ADDR_STATUS, 32'h02);
            sup(ovp[s] + 14'd1);
            rdc(CIS_ADDR_STATUS, 32'h30);
            sup(14'd6000);
            rdc(CIS_ADDR_STATUS, 32'h30);
            sup(14'd5999);
            rdc(CIS_ADDR_STATUS, 32'h02);
        end
        rdc(CIS_ADDR_IRQSTAT, 32'h7);
        wrc(CIS_ADDR_IRQEN, 32'h4);
        cyc(2);
        chk(irq_out_n, 1'b0);
        sup(14'd9000);
        wrc(CIS_ADDR_IRQCLR, 32'h4);
        cyc(2);
        chk(irq_out_n, 1'b0);
        sup(14'd5999);
        wrc(CIS_ADDR_IRQCLR, 32'h4);
        cyc(2);
        chk(irq_out_n, 1'b1);
        rdc(CIS_ADDR_IRQSTAT, 32'h3);
        rdc(CIS_ADDR_IRQEN, 32'h4);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            ac_mode_input <= i[1];
            charge_level_input <= i[0];
            cyc(5);
            chk(inputLimitMa, lim[i]);
            chk(chargeCurrentMa, cur[i]);
            rdc(CIS_ADDR_STATUS, {29'h0, i[1], 2'b10});
        end
        chk(system_rail_source, CIS_SRC_INPUT);
        @(posedge clock);
        systemOverload <= 1'b1;
        cyc(5);
        chk(system_rail_source, CIS_SRC_BOTH);
        sup(14'd2000);
        chk(system_rail_source, CIS_SRC_BATTERY);
        sup(14'd5000);
        batteryPresent <= 1'b0;
        cyc(6);
        chk(chargeSuspend, 1'b1);
        batteryPresent <= 1'b1;
        cyc(6);
        chk(chargeEnable, 1'b1);
        host.rd(8'h20, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, AXI_SLVERR});
        host.wr(8'h20, 32'h1, r);
        chk({30'h0, r}, {30'h0, AXI_SLVERR});
        conclude();
    end
endmodule
